// [dv/hiak_assertions.sv]
// port checker of the host interrupt acknowledge block
`timescale 1ns/1ps
module hiak_assertions (
    input wire logic ref_clk, rst, chip_select_n, data_strobe_n, rd_strobe_n, wr_strobe_n,
    input wire logic irq_ack_n, chain_enable_in, chain_enable_in0, casc_mode, port_irq_en,
    input wire logic [1:0] irq_drive, slave_addr,
    input wire logic transfer_ack_o, transfer_ack_oe_n, irq_o, irq_oe_n, vec_data_oe_n,
    input wire logic [7:0] channel_irq_mask_a, channel_irq_mask_b, port_irq_mask, vec_data_o,
    input wire logic [7:0] channel_irq_status_a, channel_irq_status_b, port_irq_status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // request asserted on the pin, whatever the driver style
    wire req_on = !irq_oe_n && (irq_o == (irq_drive == hiak_pkg::DRV_PP_HIGH));
    // any unmasked status left pending, port status only while port requests are on
    wire pend = |(channel_irq_status_a & ~channel_irq_mask_a)
        | |(channel_irq_status_b & ~channel_irq_mask_b)
        | (port_irq_en & |(port_irq_status & ~port_irq_mask));
    // host has released every strobe and select
    wire idle = irq_ack_n && data_strobe_n && rd_strobe_n && wr_strobe_n && chip_select_n;
    tack_release_a: assert property (!transfer_ack_oe_n && idle |-> ##[1:4] transfer_ack_oe_n)
        else $error("transfer ack outlives its cycle");
    tack_level_a: assert property (!transfer_ack_oe_n |-> !transfer_ack_o)
        else $error("transfer ack driven high");
    tack_cause_a: assert property ($fell(transfer_ack_oe_n) |-> !irq_ack_n || !chip_select_n)
        else $error("transfer ack without a cycle");
    vec_cause_a: assert property ($fell(vec_data_oe_n) |-> !irq_ack_n)
        else $error("vector driven outside acknowledge");
    vec_stable_a: assert property (!vec_data_oe_n && !$past(vec_data_oe_n) |-> $stable(vec_data_o))
        else $error("vector changed while driven");
    vec_release_a: assert property (irq_ack_n [*4] |-> vec_data_oe_n)
        else $error("data byte not released");
    mask_off_a: assert property (!pend [*3] |-> !req_on)
        else $error("request with nothing pending");
    req_rise_a: assert property (!casc_mode && irq_ack_n && $rose(pend) |-> ##[1:3] req_on)
        else $error("pending source gave no request");
    daisy_drop_a: assert property ((casc_mode && !chain_enable_in) [*4] |-> !req_on)
        else $error("daisy request with chain low");
    slave_miss_a: assert property
        ((!casc_mode && {chain_enable_in, chain_enable_in0} != slave_addr) [*5] |-> vec_data_oe_n)
        else $error("vector given to another address");
endmodule
bind hiak_top hiak_assertions u_chk (.*);

// [dv/hiak_host_model.sv]
// host bus model running register and acknowledge cycles
`timescale 1ns/1ps
module hiak_host_model (
    input wire logic ref_clk, bus_style, transfer_ack_o, transfer_ack_oe_n, vec_data_oe_n,
    input wire logic [7:0] vec_data_o,
    output logic chip_select_n, data_strobe_n, rd_strobe_n, wr_strobe_n,
    output logic irq_ack_n, dma_ack_a_n, dma_ack_b_n
);
    logic [7:0] last; // last byte seen, so a released bus shows no stale value
    wire tack_w = transfer_ack_oe_n ? 1'b1 : transfer_ack_o; // pulled up when undriven
    wire [7:0] data_w = vec_data_oe_n ? ~last : vec_data_o;
    initial
    begin
        {chip_select_n, data_strobe_n, rd_strobe_n, wr_strobe_n} = 4'hf;
        {irq_ack_n, dma_ack_a_n, dma_ack_b_n} = 3'h7;
        last = 8'h00;
    end
    // one cycle: ia picks acknowledge, else register read; held until ack or timeout
    task automatic cyc(input logic ia, output logic t, output logic v, output logic [7:0] d);
        int n;
        t = 1'b0;
        @(negedge ref_clk);
        irq_ack_n = !ia;
        chip_select_n = ia;
        if (bus_style == hiak_pkg::BUS_DATA_STROBE)
            data_strobe_n = 1'b0;
        else if (!ia)
            rd_strobe_n = 1'b0;
        for (n = 0; n < 20 && !t; n++)
        begin
            @(posedge ref_clk);
            t = !tack_w;
        end
        v = !vec_data_oe_n;
        d = data_w;
        last = d;
        @(negedge ref_clk);
        {chip_select_n, data_strobe_n, rd_strobe_n, irq_ack_n} = 4'hf;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

// [dv/hiak_top_tb_top.sv]
// testbench of the host interrupt acknowledge block
`timescale 1ns/1ps
module hiak_top_tb_top;
    logic ref_clk, rst, access_ready, bus_style, casc_mode, port_irq_en, t, v;
    logic chain_enable_in, chain_enable_in0, chip_select_n, data_strobe_n, rd_strobe_n;
    logic wr_strobe_n, irq_ack_n, dma_ack_a_n, dma_ack_b_n, transfer_ack_o, transfer_ack_oe_n;
    logic irq_o, irq_oe_n, chain_enable_out, vec_data_oe_n;
    logic [1:0] irq_drive, slave_addr;
    logic [7:0] channel_src_a, channel_src_b, port_src, clr_stat_a, clr_stat_b, clr_port_stat;
    logic [7:0] channel_irq_mask_a, channel_irq_mask_b, port_irq_mask, vec_data_o, d, s;
    logic [7:0] global_irq_summary, channel_irq_status_a, channel_irq_status_b, port_irq_status;
    int error_cnt = 0;
    int samples_checked = 0;
    hiak_top dut (.*);
    hiak_host_model host (.*);
    always #50 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one-cycle set pulses, or clear pulses when c is high
    task automatic pulse(input logic [7:0] a, b, p, input logic c);
        @(negedge ref_clk);
        if (c)
            {clr_stat_a, clr_stat_b, clr_port_stat} = {a, b, p};
        else
            {channel_src_a, channel_src_b, port_src} = {a, b, p};
        @(negedge ref_clk);
        {channel_src_a, channel_src_b, port_src} = 24'h00_0000;
        {clr_stat_a, clr_stat_b, clr_port_stat} = 24'h00_0000;
        repeat (5) @(negedge ref_clk);
    endtask
    // acknowledge cycle: expected answer, vector presence and group
    task automatic ack(input logic et, ev, input logic [2:0] eg);
        host.cyc(1'b1, t, v, d);
        chk({6'h00, t, v}, {6'h00, et, ev});
        if (ev)
            chk({5'h00, d[2:0]}, {5'h00, eg});
    endtask
    // watchdog sized well above the whole sequence
    initial
    begin
        #200_000;
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        access_ready = 1'b1;
        bus_style = hiak_pkg::BUS_DATA_STROBE;
        casc_mode = hiak_pkg::CASC_SLAVE;
        irq_drive = hiak_pkg::DRV_PP_LOW;
        slave_addr = 2'h0;
        port_irq_en = 1'b1;
        {chain_enable_in, chain_enable_in0} = 2'h0;
        {channel_src_a, channel_src_b, port_src} = 24'h00_0000;
        {clr_stat_a, clr_stat_b, clr_port_stat} = 24'h00_0000;
        {channel_irq_mask_a, channel_irq_mask_b, port_irq_mask} = 24'h00_0000;
        repeat (3) @(negedge ref_clk);
        chk({4'h0, transfer_ack_oe_n, irq_oe_n, vec_data_oe_n, irq_o}, 8'h0f);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(channel_irq_status_a | channel_irq_status_b | port_irq_status, 8'h00);
        host.cyc(1'b0, t, v, d);
        chk({7'h00, t}, 8'h01);
        // no transfer ack while the register path is not ready
        access_ready = 1'b0;
        host.cyc(1'b0, t, v, d);
        chk({7'h00, t}, 8'h00);
        access_ready = 1'b1;
        // a masked source must stay silent, then request once unmasked
        channel_irq_mask_a = 8'h01;
        pulse(8'h01, 8'h00, 8'h00, 1'b0);
        chk({7'h00, irq_o}, 8'h01);
        ack(1'b0, 1'b0, 3'h0);
        channel_irq_mask_a = 8'h00;
        repeat (3) @(negedge ref_clk);
        chk({7'h00, irq_o}, 8'h00);
        chk(channel_irq_status_a, 8'h01);
        // each newer group outranks all pending ones
        for (int g = 0; g < 6; g++)
        begin
            s = 8'h01 << (4 * (g % 2));
            pulse(g / 2 == 0 ? s : 8'h00, g / 2 == 1 ? s : 8'h00, g / 2 == 2 ? s : 8'h00, 1'b0);
            ack(1'b1, 1'b1, g[2:0]);
        end
        chk(global_irq_summary, 8'h3f);
        chk(channel_irq_status_b, 8'h11);
        chk(port_irq_status, 8'h11);
        // port groups drop out of the summary while port requests are off
        port_irq_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(global_irq_summary, 8'h0f);
        port_irq_en = 1'b1;
        pulse(8'hff, 8'hff, 8'hff, 1'b1);
        chk({7'h00, irq_o}, 8'h01);
        // driver styles with a request standing, then open drain idle
        pulse(8'h01, 8'h00, 8'h00, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            irq_drive = k[1:0];
            repeat (3) @(negedge ref_clk);
            chk({6'h00, irq_o, irq_oe_n}, k == 1 ? 8'h02 : 8'h00);
        end
        pulse(8'h01, 8'h00, 8'h00, 1'b1);
        chk({7'h00, irq_oe_n}, 8'h01);
        irq_drive = hiak_pkg::DRV_PP_LOW;
        bus_style = hiak_pkg::BUS_RW_STROBES;
        pulse(8'h01, 8'h00, 8'h00, 1'b0);
        ack(1'b1, 1'b0, 3'h0);
        ack(1'b1, 1'b1, 3'h0);
        bus_style = hiak_pkg::BUS_DATA_STROBE;
        slave_addr = 2'h2;
        ack(1'b0, 1'b0, 3'h0);
        chain_enable_in = 1'b1;
        ack(1'b1, 1'b1, 3'h0);
        casc_mode = hiak_pkg::CASC_DAISY;
        chain_enable_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({7'h00, irq_o}, 8'h01);
        ack(1'b0, 1'b0, 3'h0);
        chain_enable_in = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({7'h00, irq_o}, 8'h00);
        chk({7'h00, chain_enable_out}, 8'h00);
        ack(1'b1, 1'b1, 3'h0);
        // nothing pending: request off and the chain passed on
        pulse(8'hff, 8'hff, 8'hff, 1'b1);
        chk({6'h00, irq_o, chain_enable_out}, 8'h03);
        end_of_test;
    end
endmodule

// [hw/hiak_pkg.sv]
// package of constants and types for the host interrupt acknowledge block
package hiak_pkg;
    // driver styles of the request output
    localparam logic [1:0] DRV_PP_LOW = 2'h0;
    localparam logic [1:0] DRV_PP_HIGH = 2'h1;
    localparam logic [1:0] DRV_OPEN_DRAIN = 2'h2;
    // cascading modes
    localparam logic CASC_SLAVE = 1'h0;
    localparam logic CASC_DAISY = 1'h1;
    // bus styles
    localparam logic BUS_RW_STROBES = 1'h0;
    localparam logic BUS_DATA_STROBE = 1'h1;
    // group count and source widths
    localparam int NUM_GROUPS = 8;
    localparam int CH_W = 8;
    localparam int PORT_W = 8;
    // group index fields of the vector
    localparam int VEC_GRP_LSB = 0;
    localparam int VEC_GRP_W = 3;
    // reset values
    localparam logic [7:0] VEC_RESET = 8'h00;
    // time of the request output settle before acknowledging, in ns
    localparam int ACK_DELAY_NS = 100;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACK_DELAY_CYC = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // acknowledge sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_ACK,
        ST_HOLD
    } hiak_state_e;

    // whole block state
    typedef struct packed {
        logic [1:0] cs_s1;
        logic [1:0] cs_s2;
        logic [1:0] ds_s1;
        logic [1:0] ds_s2;
        logic [1:0] ack_s1;
        logic [1:0] ack_s2;
        logic [1:0] ce_s1;
        logic [1:0] ce_s2;
        hiak_state_e st;
        logic [1:0] wait_cnt;
        logic irq_ack_n_seen;
        logic irq_ack_n_second;
        logic irq_active;
        logic irq_pin_o;
        logic irq_pin_oe_n;
        logic chain_out;
        logic ack_o;
        logic ack_oe_n;
        logic [7:0] vec_o;
        logic vec_oe_n;
        logic [7:0] global_sum;
        logic [7:0] stat_a;
        logic [7:0] stat_b;
        logic [7:0] port_stat;
    } hiak_state_s;
endpackage

// [hw/hiak_top.sv]
// host interrupt request, acknowledge vector and transfer acknowledge logic
`timescale 1ns/1ps
// Function
// - transfer ack held until strobe/select/ack release
// - one request merges channel and port sources
// - masks gate each source off the request
// - summary, channel and port status readable
// - request driver style chosen by port config
// - daisy mode requests only while chain high
// - request drops on chain low in daisy mode, or none pending
// - accepted acknowledge puts vector on low byte
// - eight groups with fixed priority
// - vector names highest active group
// - data strobe style releases after one cycle
// - read/write style uses two acknowledge cycles
// - slave mode needs request and matching address
// - daisy mode needs request and chain high
// - chip select ignored in acknowledge cycles
module hiak_top (
    input wire logic ref_clk,
    input wire logic rst,
    // pins from the host bus
    input wire logic chip_select_n,
    input wire logic data_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic irq_ack_n,
    input wire logic dma_ack_a_n,
    input wire logic dma_ack_b_n,
    input wire logic chain_enable_in,
    input wire logic chain_enable_in0,
    // ready from the register access path
    input wire logic access_ready,
    // configuration
    input wire logic bus_style,
    input wire logic casc_mode,
    input wire logic [1:0] irq_drive,
    input wire logic [1:0] slave_addr,
    input wire logic port_irq_en,
    // sources, masks and their clear
    input wire logic [7:0] channel_src_a,
    input wire logic [7:0] channel_src_b,
    input wire logic [7:0] port_src,
    input wire logic [7:0] channel_irq_mask_a,
    input wire logic [7:0] channel_irq_mask_b,
    input wire logic [7:0] port_irq_mask,
    input wire logic [7:0] clr_stat_a,
    input wire logic [7:0] clr_stat_b,
    input wire logic [7:0] clr_port_stat,
    // pins toward the host bus
    output logic transfer_ack_o,
    output logic transfer_ack_oe_n,
    output logic irq_o,
    output logic irq_oe_n,
    output logic chain_enable_out,
    output logic [7:0] vec_data_o,
    output logic vec_data_oe_n,
    // status readback
    output logic [7:0] global_irq_summary,
    output logic [7:0] channel_irq_status_a,
    output logic [7:0] channel_irq_status_b,
    output logic [7:0] port_irq_status
);

    hiak_pkg::hiak_state_s q, d;

    // fixed priority encoder: group 7 is highest
    // the order is wired in, so no setting can reorder the groups
    function automatic logic [2:0] top_group(input logic [7:0] g);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < hiak_pkg::NUM_GROUPS; i++)
        begin
            if (g[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [7:0] grp;
    logic pending;
    logic strobe_n;
    logic bus_active;
    logic irq_ack_n_act;
    logic ce1;
    logic [1:0] addr_in;
    logic accept;

    // next state
    always_comb
    begin
        d = q;
        // two-stage synchronisers for every pin
        // the two dma acks are merged ahead of the flops; a glitch costs one cycle at most
        d.cs_s1 = {dma_ack_a_n & dma_ack_b_n, chip_select_n};
        d.cs_s2 = q.cs_s1;
        d.ds_s1 = {rd_strobe_n & wr_strobe_n, data_strobe_n};
        d.ds_s2 = q.ds_s1;
        d.ack_s1 = {1'b0, irq_ack_n};
        d.ack_s2 = q.ack_s1;
        d.ce_s1 = {chain_enable_in0, chain_enable_in};
        d.ce_s2 = q.ce_s1;
        irq_ack_n_act = ~q.ack_s2[0];
        ce1 = q.ce_s2[0];
        addr_in = {q.ce_s2[0], q.ce_s2[1]};
        // the acknowledge pin is the strobe of its own cycle in the separate strobe style
        if (bus_style == hiak_pkg::BUS_DATA_STROBE)
        begin
            strobe_n = q.ds_s2[0];
        end
        else
        begin
            strobe_n = q.ds_s2[1] & q.ack_s2[0];
        end
        // status: set wins over clear
        d.stat_a = (q.stat_a & ~clr_stat_a) | channel_src_a;
        d.stat_b = (q.stat_b & ~clr_stat_b) | channel_src_b;
        d.port_stat = (q.port_stat & ~clr_port_stat) | port_src;
        // eight groups: one per half of each channel and port register, two spares
        grp[0] = |(q.stat_a[3:0] & ~channel_irq_mask_a[3:0]);
        grp[1] = |(q.stat_a[7:4] & ~channel_irq_mask_a[7:4]);
        grp[2] = |(q.stat_b[3:0] & ~channel_irq_mask_b[3:0]);
        grp[3] = |(q.stat_b[7:4] & ~channel_irq_mask_b[7:4]);
        grp[4] = port_irq_en & |(q.port_stat[3:0] & ~port_irq_mask[3:0]);
        grp[5] = port_irq_en & |(q.port_stat[7:4] & ~port_irq_mask[7:4]);
        grp[6] = 1'b0;
        grp[7] = 1'b0;
        d.global_sum = grp;
        pending = |grp;
        // chip select only qualifies register accesses, never acknowledge
        bus_active = ~strobe_n & ~q.cs_s2[0] & ~irq_ack_n_act & q.cs_s2[1];
        // acceptance per cascading mode
        if (casc_mode == hiak_pkg::CASC_DAISY)
        begin
            accept = q.irq_active & ce1;
        end
        else
        begin
            accept = q.irq_active & (addr_in == slave_addr);
        end
        // request generation
        if (casc_mode == hiak_pkg::CASC_DAISY && !ce1)
        begin
            d.irq_active = 1'b0;
        end
        else if (!pending)
        begin
            d.irq_active = 1'b0;
        end
        else if (q.st == hiak_pkg::ST_IDLE && !q.irq_ack_n_seen)
        begin
            d.irq_active = 1'b1;
        end
        // daisy chain pass-on: blocked while we request or chain low
        // uses the next request value so the chain is blocked on the same edge
        d.chain_out = (casc_mode == hiak_pkg::CASC_DAISY) ? (ce1 & ~d.irq_active) : 1'b0;
        // acknowledge sequencer
        unique case (q.st)
            hiak_pkg::ST_IDLE:
            begin
                // reload the settle count while no cycle runs
                d.wait_cnt = 2'(hiak_pkg::ACK_DELAY_CYC);
                if ((irq_ack_n_act && accept && !strobe_n) || bus_active)
                begin
                    d.st = hiak_pkg::ST_WAIT;
                end
            end
            hiak_pkg::ST_WAIT:
            begin
                // wait for the access path before acknowledging
                if (strobe_n)
                begin
                    d.st = hiak_pkg::ST_IDLE;
                end
                else if (q.wait_cnt > 2'h1)
                begin
                    d.wait_cnt = q.wait_cnt - 2'h1;
                end
                // acknowledge cycles never wait on the register path
                else if (irq_ack_n_act || access_ready)
                begin
                    d.st = hiak_pkg::ST_ACK;
                end
            end
            hiak_pkg::ST_ACK:
            begin
                // one cycle of acknowledge before the hold state
                d.st = hiak_pkg::ST_HOLD;
            end
            hiak_pkg::ST_HOLD:
            begin
                // ack stands until strobe, select or acknowledge drops
                if (strobe_n || (q.cs_s2[0] && !q.irq_ack_n_seen && !q.irq_ack_n_second) ||
                    (!irq_ack_n_act && (q.irq_ack_n_seen || q.irq_ack_n_second)))
                begin
                    d.st = hiak_pkg::ST_IDLE;
                    if (q.irq_ack_n_second || bus_style == hiak_pkg::BUS_DATA_STROBE)
                    begin
                        // release at end of final acknowledge cycle
                        // the request comes back below while a further source pends
                        if (q.irq_ack_n_seen || q.irq_ack_n_second)
                        begin
                            d.irq_active = 1'b0;
                        end
                        d.irq_ack_n_seen = 1'b0;
                        d.irq_ack_n_second = 1'b0;
                    end
                    // first of two cycles: ack only, the vector follows in the second
                    else if (q.irq_ack_n_seen)
                    begin
                        d.irq_ack_n_second = 1'b1;
                        d.irq_ack_n_seen = 1'b0;
                    end
                end
            end
        endcase
        if (q.st == hiak_pkg::ST_WAIT && d.st == hiak_pkg::ST_ACK && irq_ack_n_act && !q.irq_ack_n_second)
        begin
            d.irq_ack_n_seen = 1'b1;
        end
        // a further pending source keeps the request up, so it never blinks off
        // between two serviced groups; daisy mode still needs the chain high
        if (q.st == hiak_pkg::ST_HOLD && d.st == hiak_pkg::ST_IDLE && pending &&
            (casc_mode != hiak_pkg::CASC_DAISY || ce1))
        begin
            d.irq_active = 1'b1;
        end
        // drive transfer ack and vector
        // open drain: the transfer ack only ever pulls low
        d.ack_o = 1'b0;
        d.ack_oe_n = ~(d.st == hiak_pkg::ST_ACK || d.st == hiak_pkg::ST_HOLD);
        d.vec_oe_n = ~((d.st == hiak_pkg::ST_ACK || d.st == hiak_pkg::ST_HOLD) && irq_ack_n_act &&
                       (q.irq_ack_n_second || bus_style == hiak_pkg::BUS_DATA_STROBE));
        if (q.st == hiak_pkg::ST_WAIT && d.st == hiak_pkg::ST_ACK)
        begin
            // captured once, on entry to ack, so the byte stays still while driven
            d.vec_o = hiak_pkg::VEC_RESET;
            d.vec_o[hiak_pkg::VEC_GRP_LSB +: hiak_pkg::VEC_GRP_W] = top_group(grp);
        end
        // request driver style
        unique case (irq_drive)
            hiak_pkg::DRV_PP_HIGH:
            begin
                d.irq_pin_o = d.irq_active;
                d.irq_pin_oe_n = 1'b0;
            end
            hiak_pkg::DRV_OPEN_DRAIN:
            begin
                d.irq_pin_o = 1'b0;
                d.irq_pin_oe_n = ~d.irq_active;
            end
            default:
            begin
                // push-pull active low, also taken by the unused code
                d.irq_pin_o = ~d.irq_active;
                d.irq_pin_oe_n = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // strobes and selects reset to their idle level, so no false cycle follows
            q <= '0;
            q.ack_s1 <= 2'h1;
            q.ack_s2 <= 2'h1;
            q.ds_s1 <= 2'h3;
            q.ds_s2 <= 2'h3;
            q.cs_s1 <= 2'h3;
            q.cs_s2 <= 2'h3;
            // every tri-state pin driver off while in reset, chain out driven low
            q.ack_oe_n <= 1'b1;
            q.vec_oe_n <= 1'b1;
            q.irq_pin_o <= 1'b1;
            q.irq_pin_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign transfer_ack_o = q.ack_o;
    assign transfer_ack_oe_n = q.ack_oe_n;
    assign irq_o = q.irq_pin_o;
    assign irq_oe_n = q.irq_pin_oe_n;
    assign chain_enable_out = q.chain_out;
    assign vec_data_o = q.vec_o;
    assign vec_data_oe_n = q.vec_oe_n;
    assign global_irq_summary = q.global_sum;
    assign channel_irq_status_a = q.stat_a;
    assign channel_irq_status_b = q.stat_b;
    assign port_irq_status = q.port_stat;
endmodule
